// ---- hw/xmi_ext_mem_if.v ----
// External data memory interface with on-chip RAM and strobe sequencer
`include "xmi_map.vh"
module xmi_ext_mem_if #(
	parameter RAM_AW = `XMI_RAM_AW
) (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire xm_req,
	input wire xm_write,
	input wire xm_index_form,
	input wire [7:0] xm_index,
	input wire [7:0] xm_wdata,
	output wire xm_busy,
	output wire xm_done,
	output wire [7:0] xm_rdata,
	output wire [7:0] lo_ad_out,
	output wire lo_ad_oe,
	input wire [7:0] lo_ad_in,
	output wire [7:0] lo_a_hi_out,
	output wire lo_a_hi_oe,
	output wire lo_ale,
	output wire lo_rd_n,
	output wire lo_wr_n,
	output wire lo_ctl_oe,
	output wire [7:0] hi_ad_out,
	output wire hi_ad_oe,
	input wire [7:0] hi_ad_in,
	output wire [7:0] hi_a_hi_out,
	output wire hi_a_hi_oe,
	output wire hi_ale,
	output wire hi_rd_n,
	output wire hi_wr_n,
	output wire hi_ctl_oe
);
	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam S_IDLE = 6'b000001;
	localparam S_ALEH = 6'b000010;
	localparam S_ALEL = 6'b000100;
	localparam S_SETUP = 6'b001000;
	localparam S_STRB = 6'b010000;
	localparam S_HOLD = 6'b100000;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [7:0] ptr_hi_q;
	reg [7:0] ptr_lo_q;
	reg [7:0] page_q;
	reg [7:0] cfg_q;
	reg [11:0] tim_q;
	reg aw_q;
	reg w_q;
	reg [4:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg bvalid_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [7:0] ram [0:(1<<RAM_AW)-1];
	reg [5:0] st_q;
	reg [3:0] cnt_q;
	reg [15:0] addr_q;
	reg drive_hi_q;
	reg wr_q;
	reg [7:0] wd_q;
	reg [7:0] rd_q;
	reg done_q;
	reg ext_q;
	reg port_hi_q;
	reg [7:0] lo_in_s1_q;
	reg [7:0] lo_in_s2_q;
	reg [7:0] hi_in_s1_q;
	reg [7:0] hi_in_s2_q;
	// Read sample and completion pipelines
	reg [1:0] samp_q;
	reg [1:0] fin_q;

	wire [1:0] mode = cfg_q[`XMI_CFG_MODE_HI:`XMI_CFG_MODE_LO];
	wire [1:0] t_setup = tim_q[1:0];
	wire [3:0] t_width = tim_q[5:2];
	wire [1:0] t_hold = tim_q[7:6];
	wire [1:0] t_aleh = tim_q[9:8];
	wire [1:0] t_alel = tim_q[11:10];

	// ----------------------------------------------------------------
	// Address forming and steering
	// ----------------------------------------------------------------
	wire [15:0] eff_addr = xm_index_form ? {page_q, xm_index} : {ptr_hi_q, ptr_lo_q};
	wire is_off = |eff_addr[15:12];
	// Only split mode leaves the chip; other modes stay on-chip
	wire go_ext = (mode == `XMI_MODE_SPLIT) && is_off;
	wire [RAM_AW-1:0] ram_idx = eff_addr[RAM_AW-1:0];
	wire start = xm_req && (st_q == S_IDLE);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	wire do_wr = aw_q && w_q && !bvalid_q;
	wire [4:0] ar_off = s_axi_araddr[4:0];
	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready = !w_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = 2'h0;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = 2'h0;

	function [31:0] rd_mux;
		input [4:0] off;
		begin
			case (off)
				{1'b0, `XMI_OFF_PTR_HI}: rd_mux = {24'h000000, ptr_hi_q};
				{1'b0, `XMI_OFF_PTR_LO}: rd_mux = {24'h000000, ptr_lo_q};
				{1'b0, `XMI_OFF_PAGE}: rd_mux = {24'h000000, page_q};
				{1'b0, `XMI_OFF_CFG}: rd_mux = {24'h000000, cfg_q};
				`XMI_OFF_TIMING: rd_mux = {20'h00000, tim_q};
				`XMI_OFF_STATUS: rd_mux = {26'h0, port_hi_q, ext_q, st_q == S_IDLE ? 1'b0 : 1'b1, wr_q, 2'h0};
				default: rd_mux = 32'h00000000;
			endcase
		end
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 5'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			ptr_hi_q <= 8'h00;
			ptr_lo_q <= 8'h00;
			page_q <= 8'h00;
			cfg_q <= `XMI_CFG_RESET;
			tim_q <= `XMI_TIM_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr[4:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				if (wstrb_q[0]) begin
					case (awaddr_q)
						{1'b0, `XMI_OFF_PTR_HI}: ptr_hi_q <= wdata_q[7:0];
						{1'b0, `XMI_OFF_PTR_LO}: ptr_lo_q <= wdata_q[7:0];
						{1'b0, `XMI_OFF_PAGE}: page_q <= wdata_q[7:0];
						{1'b0, `XMI_OFF_CFG}: cfg_q <= wdata_q[7:0];
						`XMI_OFF_TIMING: tim_q[7:0] <= wdata_q[7:0];
						default: ;
					endcase
				end
				if (wstrb_q[1] && awaddr_q == `XMI_OFF_TIMING)
					tim_q[11:8] <= wdata_q[11:8];
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux(ar_off);
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// On-chip RAM, one-cycle access
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (start && !go_ext && xm_write)
			ram[ram_idx] <= xm_wdata;
	end

	// ----------------------------------------------------------------
	// Pin input synchronisers
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			lo_in_s1_q <= 8'h00;
			lo_in_s2_q <= 8'h00;
			hi_in_s1_q <= 8'h00;
			hi_in_s2_q <= 8'h00;
		end else begin
			lo_in_s1_q <= lo_ad_in;
			lo_in_s2_q <= lo_in_s1_q;
			hi_in_s1_q <= hi_ad_in;
			hi_in_s2_q <= hi_in_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Strobe sequencer: ALE high, ALE low, setup, strobe, hold
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= S_IDLE;
			cnt_q <= 4'h0;
			addr_q <= 16'h0000;
			drive_hi_q <= 1'b0;
			wr_q <= 1'b0;
			wd_q <= 8'h00;
			rd_q <= 8'h00;
			done_q <= 1'b0;
			ext_q <= 1'b0;
			port_hi_q <= 1'b0;
			samp_q <= 2'h0;
			fin_q <= 2'h0;
		end else begin
			// Pin data leaves the synchroniser two edges after the strobe
			done_q <= fin_q[1];
			samp_q <= {samp_q[0], 1'b0};
			fin_q <= {fin_q[0], 1'b0};
			if (samp_q[1])
				rd_q <= port_hi_q ? hi_in_s2_q : lo_in_s2_q;
			case (st_q)
				S_IDLE: begin
					if (start) begin
						wr_q <= xm_write;
						wd_q <= xm_wdata;
						addr_q <= eff_addr;
						if (go_ext) begin
							ext_q <= 1'b1;
							port_hi_q <= cfg_q[`XMI_CFG_PORTSEL];
							drive_hi_q <= !xm_index_form;
							cnt_q <= {2'h0, t_aleh};
							st_q <= S_ALEH;
						end else begin
							ext_q <= 1'b0;
							rd_q <= ram[ram_idx];
							done_q <= 1'b1;
						end
					end
				end
				S_ALEH: begin
					if (cnt_q == 4'h0) begin
						cnt_q <= {2'h0, t_alel};
						st_q <= S_ALEL;
					end else
						cnt_q <= cnt_q - 4'h1;
				end
				S_ALEL: begin
					if (cnt_q == 4'h0) begin
						cnt_q <= {2'h0, t_setup};
						st_q <= (t_setup == 2'h0) ? S_STRB : S_SETUP;
						if (t_setup == 2'h0)
							cnt_q <= t_width;
					end else
						cnt_q <= cnt_q - 4'h1;
				end
				S_SETUP: begin
					if (cnt_q == 4'h1) begin
						cnt_q <= t_width;
						st_q <= S_STRB;
					end else
						cnt_q <= cnt_q - 4'h1;
				end
				S_STRB: begin
					if (cnt_q == 4'h0) begin
						// Last strobe cycle starts the read sample down the pipe
						samp_q[0] <= !wr_q;
						cnt_q <= {2'h0, t_hold};
						if (t_hold == 2'h0) begin
							st_q <= S_IDLE;
							// Writes finish now, reads wait for their sample
							if (wr_q)
								done_q <= 1'b1;
							else
								fin_q[0] <= 1'b1;
						end else
							st_q <= S_HOLD;
					end else
						cnt_q <= cnt_q - 4'h1;
				end
				S_HOLD: begin
					if (cnt_q == 4'h1) begin
						st_q <= S_IDLE;
						if (wr_q)
							done_q <= 1'b1;
						else
							fin_q[0] <= 1'b1;
					end else
						cnt_q <= cnt_q - 4'h1;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	wire bus_act = (st_q != S_IDLE);
	wire ale = (st_q == S_ALEH);
	wire strb = (st_q == S_STRB);
	// Muxed bus carries low address while ALE phases, then write data
	wire addr_ph = (st_q == S_ALEH) || (st_q == S_ALEL);
	wire [7:0] ad_v = addr_ph ? addr_q[7:0] : wd_q;
	wire ad_en = bus_act && (addr_ph || wr_q);
	wire hi_en = bus_act && drive_hi_q;

	assign lo_ad_out = ad_v;
	assign lo_ad_oe = ad_en && !port_hi_q;
	assign lo_a_hi_out = addr_q[15:8];
	assign lo_a_hi_oe = hi_en && !port_hi_q;
	assign lo_ale = ale && !port_hi_q;
	assign lo_rd_n = !(strb && !wr_q && !port_hi_q);
	assign lo_wr_n = !(strb && wr_q && !port_hi_q);
	assign lo_ctl_oe = bus_act && !port_hi_q;
	assign hi_ad_out = ad_v;
	assign hi_ad_oe = ad_en && port_hi_q;
	assign hi_a_hi_out = addr_q[15:8];
	assign hi_a_hi_oe = hi_en && port_hi_q;
	assign hi_ale = ale && port_hi_q;
	assign hi_rd_n = !(strb && !wr_q && port_hi_q);
	assign hi_wr_n = !(strb && wr_q && port_hi_q);
	assign hi_ctl_oe = bus_act && port_hi_q;
	assign xm_busy = bus_act;
	assign xm_done = done_q;
	assign xm_rdata = rd_q;
endmodule

// ---- hw/xmi_map.vh ----
// Register offsets, field positions and reset values of the external memory interface
`ifndef XMI_MAP_VH
`define XMI_MAP_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define XMI_OFF_PTR_HI 4'h0
`define XMI_OFF_PTR_LO 4'h4
`define XMI_OFF_PAGE 4'h8
`define XMI_OFF_CFG 4'hc
// Timing register and status at 0x10 and 0x14 (5-bit index)
`define XMI_OFF_TIMING 5'h10
`define XMI_OFF_STATUS 5'h14
// ----------------------------------------------------------------
// Config fields
// ----------------------------------------------------------------
`define XMI_CFG_MODE_HI 3
`define XMI_CFG_MODE_LO 2
`define XMI_CFG_PORTSEL 5
`define XMI_MODE_ONCHIP 2'h0
`define XMI_MODE_SPLIT 2'h1
// ----------------------------------------------------------------
// Timing fields: setup[1:0], width-1[5:2], hold[7:6], ale high-1[9:8], ale low-1[11:10]
// ----------------------------------------------------------------
`define XMI_TIM_RESET 12'hfff
`define XMI_CFG_RESET 8'h00
`define XMI_RAM_AW 12
`endif

// ---- verif/tb_xmi_ext_mem_if.sv ----
// Directed test of the external data memory interface
module tb_xmi_ext_mem_if;
	timeunit 1ns;
	timeprecision 1ps;
	reg aclk = 0;
	reg aresetn = 0;
	reg [31:0] awaddr = 0, wdata = 0, araddr = 0;
	reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg req = 0, wr = 0, idx = 0, ta, tw;
	reg [7:0] ix = 0, xd = 0;
	wire [31:0] rdata;
	wire [1:0] bresp, rresp;
	wire awready, wready, bvalid, arready, rvalid, busy, done;
	wire [7:0] xr, la, lh, ha, hh, lm, hm;
	wire lao, lho, lale, lrd_n, lwr_n, hao, hho, hale, hrd_n, hwr_n;
	wire [7:0] lin = lao ? la : lm;
	wire [7:0] hin = hao ? ha : hm;
	integer mismatches = 0, cmp_count = 0, nb, ns, k;
	always #2.5 aclk = ~aclk;
	xmi_ext_mem_if i_xmi_ext_mem_if (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.xm_req(req), .xm_write(wr), .xm_index_form(idx), .xm_index(ix), .xm_wdata(xd),
		.xm_busy(busy), .xm_done(done), .xm_rdata(xr), .lo_ad_out(la), .lo_ad_oe(lao),
		.lo_ad_in(lin), .lo_a_hi_out(lh), .lo_a_hi_oe(lho), .lo_ale(lale), .lo_rd_n(lrd_n),
		.lo_wr_n(lwr_n), .lo_ctl_oe(), .hi_ad_out(ha), .hi_ad_oe(hao), .hi_ad_in(hin),
		.hi_a_hi_out(hh), .hi_a_hi_oe(hho), .hi_ale(hale), .hi_rd_n(hrd_n), .hi_wr_n(hwr_n),
		.hi_ctl_oe());
	xmi_mem i_xmi_mem_lo (.clk(aclk), .ale(lale), .rd_n(lrd_n), .wr_n(lwr_n), .ad(lin),
		.a_hi(lh), .a_hi_oe(lho), .ad_drv(lm));
	xmi_mem i_xmi_mem_hi (.clk(aclk), .ale(hale), .rd_n(hrd_n), .wr_n(hwr_n), .ad(hin),
		.a_hi(hh), .a_hi_oe(hho), .ad_drv(hm));
	task chk(input [39:0] g, e);
		begin
			cmp_count++;
			if (g !== e) begin
				mismatches++;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// Register write (w=1) or read with expected value (w=0)
	task axi(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge aclk);
			{awaddr, araddr, wdata} <= {24'h0, a, 24'h0, a, d};
			{awvalid, wvalid, arvalid, bready, rready} <= {w, w, !w, w, !w};
			{ta, tw} = {1'b0, !w};
			while (!(ta && tw)) begin
				@(negedge aclk);
				{ta, tw} = {ta || (w ? awready : arready), tw || wready};
				@(posedge aclk);
				{awvalid, wvalid, arvalid} <= {w && !ta, w && !tw, !w && !ta};
			end
			while (!(w ? bvalid : rvalid)) @(negedge aclk);
			chk({w ? bresp : rresp, w ? 32'h0 : rdata}, {2'h0, w ? 32'h0 : d});
			@(posedge aclk);
			{bready, rready} <= 2'h0;
		end
	endtask
	// Core access; counts busy and strobe cycles until done
	task xc(input w, f, input [7:0] i, d, e, eb, es);
		begin
			@(posedge aclk);
			{req, wr, idx, ix, xd} <= {1'b1, w, f, i, d};
			@(posedge aclk);
			req <= 0;
			nb = 0;
			ns = 0;
			@(negedge aclk);
			while (!done) begin
				nb += busy;
				ns += !(lrd_n && lwr_n && hrd_n && hwr_n);
				@(negedge aclk);
			end
			chk({w ? 8'h0 : xr, nb[7:0], ns[7:0]}, {e, eb, es});
		end
	endtask
	task report_and_stop;
		begin
			if (mismatches == 0 && cmp_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		axi(0, 8'h0c, 32'h0);
		axi(0, 8'h10, 32'hfff);
		axi(0, 8'h1c, 32'h0);
		axi(1, 8'h00, 32'h12);
		axi(1, 8'h04, 32'h34);
		axi(0, 8'h00, 32'h12);
		axi(0, 8'h04, 32'h34);
		xc(1, 0, 0, 8'ha5, 0, 0, 0);
		axi(1, 8'h00, 32'h02);
		xc(0, 0, 0, 0, 8'ha5, 0, 0);
		axi(1, 8'h08, 32'h22);
		for (k = 0; k < 4; k++) begin
			axi(1, 8'h0c, k << 2);
			if (k != 1)
				xc(0, 1, 8'h34, 0, 8'ha5, 0, 0);
		end
		axi(1, 8'h0c, 32'h04);
		xc(0, 0, 0, 0, 8'ha5, 0, 0);
		axi(1, 8'h00, 32'h12);
		xc(1, 0, 0, 8'h5a, 0, 30, 16);
		chk({i_xmi_mem_lo.hi_q, i_xmi_mem_lo.m[16'h1234]}, 9'h15a);
		xc(0, 0, 0, 0, 8'h5a, 30, 16);
		axi(1, 8'h10, 32'h0);
		axi(1, 8'h08, 32'h10);
		xc(1, 1, 8'h77, 8'h3c, 0, 3, 1);
		chk({i_xmi_mem_lo.hi_q, i_xmi_mem_lo.m[16'hff77]}, 9'h03c);
		xc(0, 1, 8'h77, 0, 8'h3c, 3, 1);
		axi(1, 8'h08, 32'h02);
		xc(0, 1, 8'h34, 0, 8'ha5, 0, 0);
		axi(1, 8'h10, 32'h0c);
		axi(1, 8'h0c, 32'h24);
		axi(1, 8'h00, 32'h20);
		xc(1, 0, 0, 8'h99, 0, 6, 4);
		chk(i_xmi_mem_hi.m[16'h2034], 8'h99);
		xc(0, 0, 0, 0, 8'h99, 6, 4);
		axi(0, 8'h14, 32'h30);
		report_and_stop;
	end
	initial begin
		#100000;
		mismatches++;
		report_and_stop;
	end
endmodule

// ---- verif/xmi_ext_mem_if_sva.sv ----
// Strobe sequencer checks on the lower port group
module xmi_ext_mem_if_sva (
	input wire aclk,
	input wire aresetn,
	input wire xm_req,
	input wire xm_busy,
	input wire xm_done,
	input wire lo_ale,
	input wire lo_rd_n,
	input wire lo_wr_n,
	input wire lo_ad_oe,
	input wire lo_ctl_oe,
	input wire hi_ctl_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	wire stb = !(lo_rd_n && lo_wr_n);
	reg [4:0] stb_cnt_q;
	always @(posedge aclk)
		stb_cnt_q <= (!aresetn || !stb) ? 5'h0 : stb_cnt_q + 5'h1;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_TAKE: assert property (xm_req && !xm_busy |=> xm_busy || xm_done)
		else $error("Request lost");
	AST_ALE_MAX: assert property (lo_ale [*4] |=> !lo_ale)
		else $error("Latch enable too long");
	AST_ALE_BUSY: assert property (lo_ale |-> xm_busy && !stb)
		else $error("Latch enable misplaced");
	AST_SETUP: assert property ($past(aresetn) && $fell(lo_ale) |-> !stb)
		else $error("Strobe too early");
	AST_WIDTH: assert property (stb_cnt_q <= 5'h10)
		else $error("Strobe too wide");
	AST_HOLD: assert property ($past(aresetn) && $rose(!stb) |-> ##[0:5] xm_done)
		else $error("Hold too long");
	AST_END: assert property ($past(aresetn) && $fell(xm_busy) |-> ##[0:2] xm_done)
		else $error("Busy fell without done");
	AST_PORT_SEL: assert property ((lo_ctl_oe || hi_ctl_oe) == xm_busy && !(lo_ctl_oe && hi_ctl_oe))
		else $error("Port group enable wrong");
	AST_RD_FREE: assert property (!lo_rd_n |-> !lo_ad_oe)
		else $error("Bus driven in read");
	COV_RD: cover property ($fell(lo_rd_n));
	COV_WR: cover property ($fell(lo_wr_n));
	COV_ONCHIP: cover property (xm_done && !$past(xm_busy, 3));
endmodule
bind xmi_ext_mem_if xmi_ext_mem_if_sva i_sva (.aclk, .aresetn, .xm_req, .xm_busy, .xm_done,
	.lo_ale, .lo_rd_n, .lo_wr_n, .lo_ad_oe, .lo_ctl_oe, .hi_ctl_oe);

// ---- verif/xmi_mem.sv ----
// Off-chip byte memory model for one port group
module xmi_mem (
	input wire clk,
	input wire ale,
	input wire rd_n,
	input wire wr_n,
	input wire [7:0] ad,
	input wire [7:0] a_hi,
	input wire a_hi_oe,
	output wire [7:0] ad_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [7:0] m [0:65535];
	reg [15:0] a_q = 16'h0;
	reg hi_q = 1'b0;
	reg [7:0] last_q = 8'h0;
	// Released bus toggles every cycle so stale data never matches
	assign ad_drv = rd_n ? ~last_q : m[a_q];
	always @(posedge clk) begin
		last_q <= ad_drv;
		if (ale)
			{hi_q, a_q} <= {a_hi_oe, a_hi_oe ? a_hi : 8'hff, ad};
		if (!wr_n)
			m[a_q] <= ad;
	end
endmodule
